/* rgbx_cfg.svh */
/*
 * constants for the request/grant bus exchange block
 * assumes inclusion by rgbx_line_port and rgbx_arbiter only
 */
`ifndef RGBX_CFG_SVH
`define RGBX_CFG_SVH

`define RGBX_IDLE_WINDOW_CLKS   3
`define RGBX_GAP_CLKS           1
`define RGBX_STATUS_PASSIVE     3'h7
`define RGBX_LINE_REST          1'b1
`define RGBX_LINE_ACTIVE        1'b0

`endif

/* rgbx_pkg.sv */
/*
 * types for the request/grant bus exchange block
 * assumes rgbx_cfg.svh is on the include path
 */
package rgbx_pkg;

	typedef enum logic [1:0]
	{
		RGBX_BS_IDLE   = 2'h0,
		RGBX_BS_FIRST  = 2'h1,
		RGBX_BS_SECOND = 2'h2,
		RGBX_BS_LATER  = 2'h3
	} rgbx_bus_phase_t;

	// qualifiers of the bus cycle in progress, from the bus interface
	typedef struct packed
	{
		logic            cyc_pending;
		logic            is_memory;
		logic            odd_low_byte;
		logic            inta_first;
		logic            locked;
		logic            final_bus_state;
		rgbx_bus_phase_t phase;
	} rgbx_cycle_info_t;

	// one request/grant line as three signals
	typedef struct packed
	{
		logic line_in;
		logic line_out;
		logic line_oe_n;
	} rgbx_line_t;

endpackage

/* rgbx_line_port.sv */
/*
 * one request/grant line: pulse detect and one-clock grant drive
 * assumes the line input is synchronous to core_clk_i
 */
module rgbx_line_port
	import rgbx_pkg::*;
(
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	// pin side
	input  wire logic line_i,
	output logic      line_o,
	output logic      line_oe_n_o,
	// core side
	input  wire logic drive_grant_i,
	output logic      pulse_o
);
`include "rgbx_cfg.svh"

	logic line_q;

	// undriven line is pulled up; falling edge marks a pulse
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			line_q <= `RGBX_LINE_REST; // [RULE2]
		else
			line_q <= line_i; // [RULE19]
	end

	assign pulse_o = (line_i == `RGBX_LINE_ACTIVE) && (line_q == `RGBX_LINE_REST); // [RULE10]

	// drive low for exactly one clock only when granting
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			line_o      <= `RGBX_LINE_REST;
			line_oe_n_o <= 1'b1;
		end
		else
		begin
			line_o      <= drive_grant_i ? `RGBX_LINE_ACTIVE : `RGBX_LINE_REST; // [RULE10]
			line_oe_n_o <= !drive_grant_i; // [RULE20]
		end
	end

endmodule

/* rgbx_arbiter.sv */
/*
 * request/grant bus exchange for a processor and two other bus masters
 * assumes cycle qualifiers come from the bus interface in the same clock
 */
// Notes on behaviour
// RULE1 - two request/grant lines; high priority line wins simultaneous requests
// RULE2 - unconnected line reads inactive through pull-up hold; no spurious request
// RULE3 - master requests with a single one-clock low pulse
// RULE4 - grant pulse one clock in final or idle state, float, then granted
// RULE5 - while granted the bus interface starts no bus activity
// RULE6 - master's third pulse releases; device retakes bus next clock
// RULE7 - after retake go to final state if cycle pending, else idle
// RULE8 - each exchange is exactly request, grant, release pulses
// RULE9 - at least one idle clock after each exchange before next pulse
// RULE10 - all pulses are low; line rests high
// RULE11 - request in memory cycle releases at its final state if conditions hold
// RULE12 - request must come by second state, else release deferred
// RULE13 - no release after low byte of odd-address word
// RULE14 - no release after first interrupt acknowledge cycle
// RULE15 - no release during a locked instruction
// RULE16 - idle bus request may be granted during the next clock
// RULE17 - memory cycle within three clocks of idle request: timing counts as met; code meets it at every memory final state from the second pending clock
// RULE18 - status outputs float high during granted condition
// RULE19 - lines sampled on rising edge; pulses one clock from an edge
// RULE20 - device drives line only for grant pulse
module rgbx_arbiter
	import rgbx_pkg::*;
(
	// clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             rst_n_i,
	// request/grant lines
	input  wire logic             req_grant_line_high_prio_i,
	output logic                  req_grant_line_high_prio_o,
	output logic                  req_grant_line_high_prio_oe_n_o,
	input  wire logic             req_grant_line_low_prio_i,
	output logic                  req_grant_line_low_prio_o,
	output logic                  req_grant_line_low_prio_oe_n_o,
	// bus interface side
	input  wire rgbx_cycle_info_t cycle_i,
	input  wire logic [2:0]       cycle_status_i,
	output logic                  bus_float_o,
	output logic                  retake_final_o,
	// status pins
	output logic [2:0]            cycle_status_o,
	output logic                  cycle_status_oe_n_o
);
`include "rgbx_cfg.svh"

	typedef enum logic [2:0]
	{
		RGBX_ST_OWN     = 3'h0,
		RGBX_ST_GRANT   = 3'h1,
		RGBX_ST_GRANTED = 3'h2,
		RGBX_ST_GAP     = 3'h3
	} rgbx_state_t;

	rgbx_state_t state;
	rgbx_state_t next_state;

	logic [1:0] pulse;
	logic [1:0] drive_grant;
	logic [1:0] pend;
	logic [1:0] early;
	logic       owner;
	logic [1:0] idle_cnt;
	logic       idle_req;
	logic [$clog2(`RGBX_GAP_CLKS + 1) - 1:0] gap_cnt;

	function automatic logic release_ok(input rgbx_cycle_info_t c, input logic timing_met);
		// [RULE11] [RULE13] [RULE15]
		release_ok = timing_met && !c.odd_low_byte && !c.inta_first && !c.locked;
	endfunction

	rgbx_line_port u_port_high
	(
		.core_clk_i    (core_clk_i),
		.rst_n_i       (rst_n_i),
		.line_i        (req_grant_line_high_prio_i),
		.line_o        (req_grant_line_high_prio_o),
		.line_oe_n_o   (req_grant_line_high_prio_oe_n_o),
		.drive_grant_i (drive_grant[0]),
		.pulse_o       (pulse[0])
	);

	rgbx_line_port u_port_low
	(
		.core_clk_i    (core_clk_i),
		.rst_n_i       (rst_n_i),
		.line_i        (req_grant_line_low_prio_i),
		.line_o        (req_grant_line_low_prio_o),
		.line_oe_n_o   (req_grant_line_low_prio_oe_n_o),
		.drive_grant_i (drive_grant[1]),
		.pulse_o       (pulse[1])
	);

	// latched requests and whether each arrived by the second state
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pend  <= 2'h0;
			early <= 2'h0;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (state == RGBX_ST_OWN && pulse[i]) // [RULE3]
				begin
					pend[i]  <= 1'b1;
					early[i] <= cycle_i.phase != RGBX_BS_LATER; // [RULE12]
				end
				else if (drive_grant[i])
				begin
					pend[i]  <= 1'b0;
					early[i] <= 1'b0;
				end
				else if (pend[i] && cycle_i.final_bus_state && !early[i])
					early[i] <= 1'b1; // [RULE12]
			end
		end
	end

	// clocks since a request was latched, whether or not the bus was idle, saturating at 3
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			idle_cnt <= 2'h0;
		else if (state != RGBX_ST_OWN || pend == 2'h0)
			idle_cnt <= 2'h0;
		else if (idle_cnt != 2'(`RGBX_IDLE_WINDOW_CLKS))
			idle_cnt <= idle_cnt + 2'h1;
	end

	assign idle_req = !cycle_i.cyc_pending && cycle_i.phase == RGBX_BS_IDLE; // [RULE16]

	// grant decision in final or idle state
	always_comb
	begin
		logic go;
		logic sel;
		go          = 1'b0;
		sel         = pend[0] ? 1'b0 : 1'b1; // [RULE1]
		drive_grant = 2'h0;
		if (state == RGBX_ST_OWN && pend != 2'h0)
		begin
			if (idle_req)
				go = 1'b1; // [RULE16]
			else if (cycle_i.final_bus_state && cycle_i.is_memory)
				go = release_ok(cycle_i, early[sel] || idle_cnt != 2'h0); // [RULE17]
			else if (cycle_i.final_bus_state && !cycle_i.is_memory)
				go = release_ok(cycle_i, early[sel]); // [RULE14]
		end
		if (go)
			drive_grant[sel] = 1'b1; // [RULE4]
	end

	always_comb
	begin
		next_state = state;
		unique case (state)
			RGBX_ST_OWN:
				if (drive_grant != 2'h0)
					next_state = RGBX_ST_GRANT;
			RGBX_ST_GRANT:
				next_state = RGBX_ST_GRANTED; // [RULE4]
			RGBX_ST_GRANTED:
				if (pulse[owner])
					next_state = RGBX_ST_GAP; // [RULE6]
			RGBX_ST_GAP:
				if (gap_cnt == '0)
					next_state = RGBX_ST_OWN; // [RULE9]
			default:
				next_state = RGBX_ST_OWN;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state <= RGBX_ST_OWN;
		else
			state <= next_state; // [RULE8]
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			owner <= 1'b0;
		else if (drive_grant != 2'h0)
			owner <= drive_grant[1];
	end

	// idle clocks after an exchange before new pulses are taken
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			gap_cnt <= '0;
		else if (next_state == RGBX_ST_GAP && state != RGBX_ST_GAP)
			gap_cnt <= ($bits(gap_cnt))'(`RGBX_GAP_CLKS - 1); // [RULE9]
		else if (gap_cnt != '0)
			gap_cnt <= gap_cnt - 1'b1;
	end

	// bus interface control
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			bus_float_o    <= 1'b0;
			retake_final_o <= 1'b0;
		end
		else
		begin
			bus_float_o    <= next_state == RGBX_ST_GRANT || next_state == RGBX_ST_GRANTED; // [RULE5]
			retake_final_o <= state == RGBX_ST_GRANTED && pulse[owner] && cycle_i.cyc_pending; // [RULE7]
		end
	end

	// status pins float to passive while granted
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cycle_status_o      <= `RGBX_STATUS_PASSIVE;
			cycle_status_oe_n_o <= 1'b0;
		end
		else if (next_state == RGBX_ST_GRANTED || next_state == RGBX_ST_GRANT)
		begin
			cycle_status_o      <= `RGBX_STATUS_PASSIVE; // [RULE18]
			cycle_status_oe_n_o <= 1'b1; // [RULE18]
		end
		else
		begin
			cycle_status_o      <= cycle_status_i;
			cycle_status_oe_n_o <= 1'b0;
		end
	end

endmodule

/* rgbx_asserts.sv */
/*
 * pin checker for the request/grant exchange
 * assumes a bind onto every rgbx_arbiter
 */
module rgbx_asserts
	import rgbx_pkg::*;
(
	input wire logic             core_clk_i,
	input wire logic             rst_n_i,
	input wire logic             req_grant_line_high_prio_o,
	input wire logic             req_grant_line_high_prio_oe_n_o,
	input wire logic             req_grant_line_low_prio_o,
	input wire logic             req_grant_line_low_prio_oe_n_o,
	input wire rgbx_cycle_info_t cycle_i,
	input wire logic             bus_float_o,
	input wire logic             retake_final_o,
	input wire logic [2:0]       cycle_status_o,
	input wire logic             cycle_status_oe_n_o
);
	logic gh;
	logic gl;
	assign gh = !req_grant_line_high_prio_oe_n_o;
	assign gl = !req_grant_line_low_prio_oe_n_o;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	AST_HP_ONE: assert property ($rose(gh) |=> !gh) else $error("grant width");
	AST_LP_ONE: assert property ($rose(gl) |=> !gl) else $error("grant width");
	AST_HP_LOW: assert property (gh |-> !req_grant_line_high_prio_o) else $error("level");
	AST_LP_LOW: assert property (gl |-> !req_grant_line_low_prio_o) else $error("level");
	AST_EXCL: assert property (!(gh && gl)) else $error("two grants");
	AST_FLOAT: assert property ($rose(gh || gl) |-> $rose(bus_float_o)) else $error("float");
	AST_STAT: assert property (bus_float_o |-> cycle_status_oe_n_o && cycle_status_o == 3'h7)
		else $error("status");
	AST_ONLY: assert property ($past(bus_float_o) |-> !gh && !gl) else $error("drive");
	AST_RETAKE: assert property (retake_final_o |-> $fell(bus_float_o)) else $error("retake");
	AST_BLOCK: assert property ($rose(gh || gl) |-> !$past(cycle_i.locked)
		&& !$past(cycle_i.odd_low_byte) && !$past(cycle_i.inta_first)) else $error("blocked");
endmodule

bind rgbx_arbiter rgbx_asserts i_rgbx_asserts (.*);

/* rgbx_master_model.sv */
/*
 * behavioural bus master on one request/grant line
 * assumes line_i is the resolved, pulled-up wire
 */
module rgbx_master_model #(parameter int HOLD = 3)
(
	input  wire logic core_clk_i,
	input  wire logic go_i,
	input  wire logic line_i,
	output logic      pull_low_o,
	output logic      granted_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int n;
	task automatic pulse();
		pull_low_o = 1'b1;
		@(negedge core_clk_i);
		pull_low_o = 1'b0;
	endtask
	initial
	begin
		pull_low_o = 1'b0;
		granted_o = 1'b0;
		forever
		begin
			@(negedge core_clk_i iff go_i);
			n = 0;
			do
			begin
				if (n == 0) pulse();
				else @(negedge core_clk_i);
				n = (n + 1) % 16;
				#1;
			end while (line_i);
			granted_o = 1'b1;
			repeat (HOLD) @(negedge core_clk_i);
			pulse();
			granted_o = 1'b0;
			repeat (2) @(negedge core_clk_i);
		end
	end
endmodule

/* test_request_grant_bus_exchange.sv */
/*
 * self-checking bench for rgbx_arbiter with two masters
 * assumes rgbx_master_model on both lines
 */
module test_request_grant_bus_exchange;
	import rgbx_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i, rst_n_i, go_h, go_l, pull_h, pull_l, gr_h, gr_l;
	logic hp_o, hp_oe_n, lp_o, lp_oe_n, flt, ret, st_oe_n;
	logic [2:0] st;
	rgbx_cycle_info_t cyc;
	int n_errors = 0, checked = 0, cycles = 0;
	wire logic hl = !hp_oe_n ? hp_o : !pull_h;
	wire logic ll = !lp_oe_n ? lp_o : !pull_l;
	rgbx_arbiter i_rgbx_arbiter (.core_clk_i, .rst_n_i, .req_grant_line_high_prio_i(hl),
		.req_grant_line_high_prio_o(hp_o), .req_grant_line_high_prio_oe_n_o(hp_oe_n),
		.req_grant_line_low_prio_i(ll), .req_grant_line_low_prio_o(lp_o),
		.req_grant_line_low_prio_oe_n_o(lp_oe_n), .cycle_i(cyc), .cycle_status_i(3'h5),
		.bus_float_o(flt), .retake_final_o(ret), .cycle_status_o(st),
		.cycle_status_oe_n_o(st_oe_n));
	rgbx_master_model i_master_h (.core_clk_i, .go_i(go_h), .line_i(hl), .pull_low_o(pull_h),
		.granted_o(gr_h));
	rgbx_master_model i_master_l (.core_clk_i, .go_i(go_l), .line_i(ll), .pull_low_o(pull_l),
		.granted_o(gr_l));
	initial
	begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			complete_run();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_gr(ref logic g, input logic v);
		int n;
		n = 0;
		while (g !== v && n < 60)
		begin
			@(negedge core_clk_i);
			#1;
			n++;
		end
	endtask
	task automatic req(ref logic go);
		@(negedge core_clk_i);
		#1 go = 1'b1;
		@(negedge core_clk_i);
		#1 go = 1'b0;
	endtask
	task automatic xfer(ref logic gr, input logic pend);
		wait_gr(gr, 1'b1);
		chk(gr, 1'b1);
		chk(flt, 1'b1);
		chk({st_oe_n, st}, 4'hF);
		wait_gr(gr, 1'b0);
		chk(gr, 1'b0);
		chk(flt, 1'b0);
		chk(ret, pend);
		repeat (3) @(negedge core_clk_i);
	endtask
	task automatic t_idle();
		req(go_h);
		xfer(gr_h, 1'b0);
		req(go_l);
		xfer(gr_l, 1'b0);
		$display("test idle done");
	endtask
	task automatic t_prio();
		fork
			req(go_h);
			req(go_l);
		join
		wait_gr(gr_h, 1'b1);
		chk(gr_l, 1'b0);
		xfer(gr_h, 1'b0);
		xfer(gr_l, 1'b0);
		$display("test priority done");
	endtask
	task automatic t_block();
		for (int k = 0; k < 3; k++)
		begin
			cyc = '{1'b1, 1'b1, k == 0, k == 1, k == 2, 1'b1, RGBX_BS_SECOND};
			req(go_h);
			repeat (10) @(negedge core_clk_i);
			chk(flt, 1'b0);
			#1 cyc = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, RGBX_BS_SECOND};
			xfer(gr_h, 1'b1);
			cyc = '0;
		end
		$display("test block done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		go_h = 1'b0;
		go_l = 1'b0;
		cyc = '0;
		rst_n_i = 1'b0;
		repeat (4) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		#1;
		chk({hl, ll, flt, st_oe_n}, 4'hC);
		t_idle();
		t_prio();
		t_block();
		complete_run();
	end
endmodule
